// [ces_pkg.sv]
package ces_pkg;
    // ----------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------
    localparam logic [7:0] ADR_STATUS = 8'h00;
    localparam logic [7:0] ADR_VBASE = 8'h04;
    localparam logic [7:0] ADR_CTRL = 8'h08;
    localparam logic [7:0] ADR_BANK = 8'h0C;
    localparam int CTRL_SINGLE = 0;
    localparam int CTRL_BANK_EN = 1;
    localparam int CTRL_BANK_OVERFLOW_ACCEPT_ENABLE = 2;
    localparam int MASK_LSB = 4;
    localparam int MASK_MSB = 7;
    localparam logic [31:0] STATUS_RST = 32'h000000F0;
    localparam logic [31:0] VBASE_RST = 32'h00000000;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [3:0] MASK_NMI = 4'hF;
    // ----------------------------------------------------------
    // Priority levels and vectors
    // ----------------------------------------------------------
    localparam logic [4:0] LVL_NMI = 5'h10;
    localparam logic [4:0] LVL_FIXED = 5'h0F;
    localparam logic [8:0] VEC_CPU_AE = 9'h009;
    localparam logic [8:0] VEC_DMA_AE = 9'h00A;
    localparam logic [8:0] VEC_BANK_OVF = 9'h00F;
    localparam logic [8:0] VEC_BANK_UDF = 9'h010;
    localparam logic [3:0] BANK_FULL = 4'hF;
    localparam logic [31:0] WORD_STEP = 32'h00000004;
    // ----------------------------------------------------------
    // Address regions
    // ----------------------------------------------------------
    localparam logic [31:0] RAM_FETCH_LO = 32'hF0000000;
    localparam logic [31:0] RAM_FETCH_HI = 32'hF5FFFFFF;
    localparam logic [31:0] PERIPH_LO = 32'hFFFC0000;
    localparam logic [31:0] PERIPH_HI = 32'hFFFFFFFF;
    localparam logic [31:0] EXT_LO = 32'h04000000;
    localparam logic [31:0] EXT_HI = 32'hEFFFFFFF;
    // ----------------------------------------------------------
    // Types
    // ----------------------------------------------------------
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_DLONG} ces_size_e;
    typedef enum logic [1:0] {MS_CPU, MS_DMA, MS_DTC} ces_master_e;
    typedef enum logic [1:0] {IS_NORMAL, IS_NMI, IS_BREAK, IS_DEBUG} ces_src_e;
    typedef struct packed {
        logic valid;
        logic fetch;
        ces_master_e master;
        ces_size_e size;
        logic [31:0] addr;
    } ces_access_s;
    typedef struct packed {
        logic req;
        ces_src_e src;
        logic [3:0] level;
        logic [8:0] vector;
    } ces_irq_s;
endpackage

// [ces_addr_check.sv]
`timescale 1ns/1ps
`default_nettype none
module ces_addr_check (
    input wire ces_pkg::ces_access_s acc_i,
    input wire logic single_chip_i,
    output logic fetch_err_o,
    output logic data_err_o
);
    logic periph;
    logic ram;
    logic ext;
    logic misal;
    always_comb begin
        periph = acc_i.addr >= ces_pkg::PERIPH_LO && acc_i.addr <= ces_pkg::PERIPH_HI;
        ram = acc_i.addr >= ces_pkg::RAM_FETCH_LO && acc_i.addr <= ces_pkg::RAM_FETCH_HI;
        ext = single_chip_i && acc_i.addr >= ces_pkg::EXT_LO && acc_i.addr <= ces_pkg::EXT_HI;
        unique case (acc_i.size)
            ces_pkg::SZ_BYTE: misal = 1'b0;
            ces_pkg::SZ_WORD: misal = acc_i.addr[0];
            ces_pkg::SZ_LONG: misal = |acc_i.addr[1:0];
            ces_pkg::SZ_DLONG: misal = |acc_i.addr[2:0];
        endcase
        // Peripheral ports size their own cycles up to a longword
        if (periph && acc_i.size != ces_pkg::SZ_DLONG) begin
            misal = 1'b0;
        end
        fetch_err_o = acc_i.valid && acc_i.fetch && (acc_i.addr[0] || periph || ram || ext);
        data_err_o = acc_i.valid && !acc_i.fetch && (misal || ext);
    end
endmodule
`default_nettype wire

// [ces_irq_accept.sv]
`timescale 1ns/1ps
`default_nettype none
module ces_irq_accept (
    input wire ces_pkg::ces_irq_s irq_i,
    input wire logic [3:0] mask_i,
    output logic [4:0] level_o,
    output logic accept_o,
    output logic uses_bank_o
);
    always_comb begin
        unique case (irq_i.src)
            ces_pkg::IS_NMI: level_o = ces_pkg::LVL_NMI;
            ces_pkg::IS_BREAK, ces_pkg::IS_DEBUG: level_o = ces_pkg::LVL_FIXED;
            ces_pkg::IS_NORMAL: level_o = {1'b0, irq_i.level};
        endcase
        accept_o = irq_i.req && (irq_i.src == ces_pkg::IS_NMI || level_o > {1'b0, mask_i});
        uses_bank_o = irq_i.src == ces_pkg::IS_NORMAL || irq_i.src == ces_pkg::IS_DEBUG;
    end
endmodule
`default_nettype wire

// [ces_cpu_exception_sequencer.sv]
// Operation
// - Odd-address instruction fetch raises an address error.
// - Fetch from peripheral space or F0000000..F5FFFFFF raises an address error.
// - In single-chip mode any external space access raises an address error.
// - Odd-address 16-bit data access by any master raises an address error.
// - Unaligned 32-bit data access raises an address error.
// - 64-bit data access off an eight-byte boundary raises an address error.
// - Byte, word, longword data accesses to peripheral space never raise an error.
// - Terminate the faulting cycle; enter handling after the instruction ends.
// - Address error: fetch vector, push status, push next pc, plain jump.
// - All banks full, accept enable set, banked interrupt accepted: overflow.
// - Bank restore with no saved bank raises bank underflow.
// - Bank errors push status, then next pc or the restore's own pc.
// - Overflow entry loads mask with the causing interrupt level.
// - Non-maskable interrupt is level 16 and always accepted.
// - Break and debug interrupts have fixed level 15.
// - Pin and peripheral levels are 0..15 only.
// - Maskable interrupt accepted only when level exceeds the mask.
// - Accepted interrupt fetches vector and pushes status and pc.
// - Banked interrupts save the register context into a bank.
// - No bank save for address errors, non-maskable or break interrupts.
// - Full banks with enable clear save context to the stack instead.
// - After saving, mask gets the level (F for non-maskable), then jump.
// - Vector entry address is vector base plus four times vector number.
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ces_cpu_exception_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ces_pkg::ces_access_s acc_i,
    input wire ces_pkg::ces_irq_s irq_i,
    input wire logic insn_done_i,
    input wire logic [31:0] next_pc_i,
    input wire logic bank_restore_i,
    input wire logic [31:0] restore_pc_i,
    input wire logic [31:0] sp_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_ack_i,
    input wire logic save_done_i,
    output logic abort_o,
    output logic irq_ack_o,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    output logic bank_save_o,
    output logic stack_save_o,
    output logic [3:0] bank_index_o,
    output logic [10:0] bank_vec_offset_o,
    output logic bank_restore_ok_o,
    output logic jump_o,
    output logic [31:0] jump_pc_o,
    output logic [31:0] sp_new_o,
    output logic [31:0] status_word_o,
    output logic busy_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_VEC, ST_PUSH_SR, ST_PUSH_PC, ST_SAVE, ST_JUMP} ces_state_e;

    // ----------------------------------------------------------
    // Checkers
    // ----------------------------------------------------------
    logic [31:0] vbase_q;
    logic [2:0] ctrl_q;
    logic fetch_err;
    logic data_err;
    logic [4:0] irq_level;
    logic irq_accept;
    logic irq_banked;
    ces_addr_check u_addr_check (
        .acc_i(acc_i),
        .single_chip_i(ctrl_q[ces_pkg::CTRL_SINGLE]),
        .fetch_err_o(fetch_err),
        .data_err_o(data_err)
    );
    ces_irq_accept u_irq_accept (
        .irq_i(irq_i),
        .mask_i(status_word_o[ces_pkg::MASK_MSB:ces_pkg::MASK_LSB]),
        .level_o(irq_level),
        .accept_o(irq_accept),
        .uses_bank_o(irq_banked)
    );

    // ----------------------------------------------------------
    // Pending errors
    // ----------------------------------------------------------
    ces_state_e state_q;
    logic ae_pend_q;
    logic [8:0] ae_vec_q;
    logic udf_pend_q;
    logic [31:0] udf_pc_q;
    logic [3:0] bank_cnt_q;
    logic take_ae;
    logic take_udf;
    logic take_irq;
    logic restore_ok;
    always_comb begin
        take_ae = state_q == ST_IDLE && insn_done_i && ae_pend_q;
        take_udf = state_q == ST_IDLE && insn_done_i && !ae_pend_q && udf_pend_q;
        take_irq = state_q == ST_IDLE && insn_done_i && !ae_pend_q && !udf_pend_q && irq_accept;
        restore_ok = bank_restore_i && bank_cnt_q != 4'h0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abort_o <= 1'b0;
        end else begin
            abort_o <= fetch_err || data_err;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ae_pend_q <= 1'b0;
            ae_vec_q <= ces_pkg::VEC_CPU_AE;
        end else if (fetch_err || data_err) begin
            ae_pend_q <= 1'b1;
            ae_vec_q <= (!acc_i.fetch && acc_i.master != ces_pkg::MS_CPU) ?
                ces_pkg::VEC_DMA_AE : ces_pkg::VEC_CPU_AE;
        end else if (take_ae) begin
            ae_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            udf_pend_q <= 1'b0;
            udf_pc_q <= 32'h00000000;
        end else if (bank_restore_i && bank_cnt_q == 4'h0) begin
            udf_pend_q <= 1'b1;
            udf_pc_q <= restore_pc_i;
        end else if (take_udf) begin
            udf_pend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // Entry sequencer
    // ----------------------------------------------------------
    logic [8:0] vec_q;
    logic [31:0] ret_pc_q;
    logic [31:0] sp_q;
    logic [31:0] handler_q;
    logic [3:0] new_mask_q;
    logic set_mask_q;
    logic save_bank_q;
    logic save_stack_q;
    logic save_wait_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            vec_q <= 9'h000;
            ret_pc_q <= 32'h00000000;
            sp_q <= 32'h00000000;
            handler_q <= 32'h00000000;
            new_mask_q <= 4'h0;
            set_mask_q <= 1'b0;
            save_bank_q <= 1'b0;
            save_stack_q <= 1'b0;
            save_wait_q <= 1'b0;
            irq_ack_o <= 1'b0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 32'h00000000;
            mem_wdata_o <= 32'h00000000;
            bank_save_o <= 1'b0;
            stack_save_o <= 1'b0;
            bank_index_o <= 4'h0;
            bank_vec_offset_o <= 11'h000;
            jump_o <= 1'b0;
            jump_pc_o <= 32'h00000000;
            sp_new_o <= 32'h00000000;
        end else begin
            irq_ack_o <= 1'b0;
            bank_save_o <= 1'b0;
            stack_save_o <= 1'b0;
            jump_o <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (take_ae || take_udf || take_irq) begin
                        state_q <= ST_VEC;
                        sp_q <= sp_i;
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        save_bank_q <= 1'b0;
                        save_stack_q <= 1'b0;
                        set_mask_q <= 1'b0;
                        ret_pc_q <= next_pc_i;
                    end
                    if (take_ae) begin
                        vec_q <= ae_vec_q;
                        mem_addr_o <= vbase_q + {21'h000000, ae_vec_q, 2'b00};
                    end else if (take_udf) begin
                        vec_q <= ces_pkg::VEC_BANK_UDF;
                        ret_pc_q <= udf_pc_q;
                        mem_addr_o <= vbase_q + {21'h000000, ces_pkg::VEC_BANK_UDF, 2'b00};
                    end else if (take_irq) begin
                        irq_ack_o <= 1'b1;
                        set_mask_q <= 1'b1;
                        new_mask_q <= (irq_level == ces_pkg::LVL_NMI) ? ces_pkg::MASK_NMI : irq_level[3:0];
                        bank_vec_offset_o <= {irq_i.vector, 2'b00};
                        if (ctrl_q[ces_pkg::CTRL_BANK_EN] && irq_banked && bank_cnt_q == ces_pkg::BANK_FULL
                                && ctrl_q[ces_pkg::CTRL_BANK_OVERFLOW_ACCEPT_ENABLE]) begin
                            vec_q <= ces_pkg::VEC_BANK_OVF;
                            new_mask_q <= irq_level[3:0];
                            mem_addr_o <= vbase_q + {21'h000000, ces_pkg::VEC_BANK_OVF, 2'b00};
                        end else begin
                            vec_q <= irq_i.vector;
                            mem_addr_o <= vbase_q + {21'h000000, irq_i.vector, 2'b00};
                            save_bank_q <= ctrl_q[ces_pkg::CTRL_BANK_EN] && irq_banked
                                && bank_cnt_q != ces_pkg::BANK_FULL;
                            save_stack_q <= ctrl_q[ces_pkg::CTRL_BANK_EN] && irq_banked
                                && bank_cnt_q == ces_pkg::BANK_FULL;
                        end
                    end
                end
                ST_VEC: begin
                    if (mem_ack_i) begin
                        handler_q <= mem_rdata_i;
                        state_q <= ST_PUSH_SR;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= sp_q - ces_pkg::WORD_STEP;
                        mem_wdata_o <= status_word_o;
                    end
                end
                ST_PUSH_SR: begin
                    if (mem_ack_i) begin
                        state_q <= ST_PUSH_PC;
                        mem_addr_o <= sp_q - ces_pkg::WORD_STEP - ces_pkg::WORD_STEP;
                        mem_wdata_o <= ret_pc_q;
                    end
                end
                ST_PUSH_PC: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        sp_new_o <= mem_addr_o;
                        save_wait_q <= 1'b0;
                        state_q <= (save_bank_q || save_stack_q) ? ST_SAVE : ST_JUMP;
                    end
                end
                ST_SAVE: begin
                    if (!save_wait_q) begin
                        save_wait_q <= 1'b1;
                        bank_save_o <= save_bank_q;
                        stack_save_o <= save_stack_q;
                        bank_index_o <= bank_cnt_q;
                    end else if (save_done_i) begin
                        state_q <= ST_JUMP;
                    end
                end
                ST_JUMP: begin
                    jump_o <= 1'b1;
                    jump_pc_o <= handler_q;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bank_cnt_q <= 4'h0;
            bank_restore_ok_o <= 1'b0;
        end else begin
            bank_restore_ok_o <= restore_ok;
            if (state_q == ST_SAVE && !save_wait_q && save_bank_q) begin
                bank_cnt_q <= bank_cnt_q + 4'h1;
            end else if (restore_ok) begin
                bank_cnt_q <= bank_cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= !(state_q == ST_IDLE || (state_q == ST_JUMP));
        end
    end

    // ----------------------------------------------------------
    // Wishbone registers
    // ----------------------------------------------------------
    logic [31:0] wmask;
    logic wb_wr;
    always_comb begin
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            unique case (wb_adr_i)
                ces_pkg::ADR_STATUS: wb_dat_o <= status_word_o;
                ces_pkg::ADR_VBASE: wb_dat_o <= vbase_q;
                ces_pkg::ADR_CTRL: wb_dat_o <= {29'h00000000, ctrl_q};
                ces_pkg::ADR_BANK: wb_dat_o <= {26'h0000000, udf_pend_q, ae_pend_q, bank_cnt_q};
                default: wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vbase_q <= ces_pkg::VBASE_RST;
            ctrl_q <= ces_pkg::CTRL_RST;
        end else if (wb_wr) begin
            if (wb_adr_i == ces_pkg::ADR_VBASE) begin
                vbase_q <= (vbase_q & ~wmask) | (wb_dat_i & wmask);
            end
            if (wb_adr_i == ces_pkg::ADR_CTRL && wb_sel_i[0]) begin
                ctrl_q <= wb_dat_i[2:0];
            end
        end
    end

    // Sequencer mask update wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_word_o <= ces_pkg::STATUS_RST;
        end else if (state_q == ST_JUMP && set_mask_q) begin
            status_word_o[ces_pkg::MASK_MSB:ces_pkg::MASK_LSB] <= new_mask_q;
        end else if (wb_wr && wb_adr_i == ces_pkg::ADR_STATUS) begin
            status_word_o <= (status_word_o & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_push_sr;
        state_q == ST_PUSH_SR && mem_we_o && mem_addr_o == sp_q - ces_pkg::WORD_STEP;
    endsequence
    sequence s_push_pc;
        state_q == ST_PUSH_PC && mem_wdata_o == ret_pc_q;
    endsequence

    a_fetch_odd_abort: assert property (
        acc_i.valid && acc_i.fetch && acc_i.addr[0] |=> abort_o && ae_pend_q)
        else $error("odd fetch not aborted");
    a_word_odd_err: assert property (
        acc_i.valid && !acc_i.fetch && acc_i.size == ces_pkg::SZ_WORD && acc_i.addr[0]
            && !(acc_i.addr >= ces_pkg::PERIPH_LO) |=> abort_o)
        else $error("odd word access not flagged");
    a_defer_entry: assert property (
        state_q == ST_IDLE ##1 state_q == ST_VEC |-> $past(insn_done_i))
        else $error("entry started inside an instruction");
    a_vector_addr: assert property (
        state_q == ST_IDLE ##1 state_q == ST_VEC && $rose(mem_req_o)
            |-> mem_addr_o == vbase_q + {21'h000000, vec_q, 2'b00})
        else $error("vector entry address wrong");
    a_push_order: assert property (
        state_q == ST_VEC && mem_ack_i |=> s_push_sr ##[1:1000] s_push_pc)
        else $error("pushes out of order");
    a_mask_accept: assert property (
        irq_ack_o && irq_i.src == ces_pkg::IS_NORMAL
            |-> $past(irq_i.level) > $past(status_word_o[ces_pkg::MASK_MSB:ces_pkg::MASK_LSB]))
        else $error("interrupt taken at or below mask");
    a_nmi_mask: assert property (
        jump_o && set_mask_q && vec_q != ces_pkg::VEC_BANK_OVF && $past(new_mask_q) == ces_pkg::MASK_NMI
            |=> status_word_o[ces_pkg::MASK_MSB:ces_pkg::MASK_LSB] == ces_pkg::MASK_NMI)
        else $error("mask not loaded");
    a_no_bank_save: assert property (
        bank_save_o |-> vec_q != ces_pkg::VEC_CPU_AE && vec_q != ces_pkg::VEC_DMA_AE
            && vec_q != ces_pkg::VEC_BANK_UDF)
        else $error("bank save on non-banked entry");
    a_underflow_ret: assert property (
        take_udf |=> ret_pc_q == $past(udf_pc_q))
        else $error("underflow return address wrong");
endmodule
`default_nettype wire

// [ces_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
module ces_far_side (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic save_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o,
    output logic save_done_o
);
    logic [31:0] addr_q [0:2];
    logic [31:0] data_q [0:2];
    logic [1:0] n_q;
    logic [1:0] wait_q;
    logic slow_q;
    logic save_q;
    // Answers alternate between prompt and two wait cycles; idle read data toggles
    always_ff @(posedge clk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        save_q <= save_i;
        save_done_o <= save_q;
        if (rst_i) begin
            n_q <= 2'h0;
            wait_q <= 2'h0;
            slow_q <= 1'b0;
            mem_rdata_o <= 32'h0;
        end else if (mem_req_i && !mem_ack_o) begin
            if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end else begin
                mem_ack_o <= 1'b1;
                slow_q <= !slow_q;
                wait_q <= slow_q ? 2'h0 : 2'h2;
                addr_q[mem_we_i ? n_q : 2'h0] <= mem_addr_i;
                data_q[mem_we_i ? n_q : 2'h0] <= mem_wdata_i;
                n_q <= mem_we_i ? n_q + 2'h1 : 2'h1;
                mem_rdata_o <= 32'hA0000000 | mem_addr_i;
            end
        end
    end
endmodule
`default_nettype wire

// [tb_cpu_exception_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_exception_sequencer;
    logic clk_i, rst_i, cyc, we, insn, rb, mrq, mwe, mak, sdn, bsv, ssv, jmp, ack, abt, iak, rok;
    logic [7:0] adr;
    logic [31:0] wdat, rd, mad, mwd, mrd, jpc, dato;
    ces_pkg::ces_access_s acc;
    ces_pkg::ces_irq_s irq;
    int failures = 0;
    int checks = 0;
    int n;
    ces_cpu_exception_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack), .acc_i(acc), .irq_i(irq),
        .insn_done_i(insn), .next_pc_i(32'h3000), .bank_restore_i(rb), .restore_pc_i(32'h2FFE), .sp_i(32'h8000),
        .mem_rdata_i(mrd), .mem_ack_i(mak), .save_done_i(sdn), .abort_o(abt), .irq_ack_o(iak), .mem_req_o(mrq),
        .mem_we_o(mwe), .mem_addr_o(mad), .mem_wdata_o(mwd), .bank_save_o(bsv), .stack_save_o(ssv),
        .bank_index_o(), .bank_vec_offset_o(), .bank_restore_ok_o(rok), .jump_o(jmp), .jump_pc_o(jpc),
        .sp_new_o(), .status_word_o(), .busy_o());
    ces_far_side p (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mrq), .mem_we_i(mwe), .mem_addr_i(mad),
        .mem_wdata_i(mwd), .save_i(bsv | ssv), .mem_ack_o(mak), .mem_rdata_o(mrd), .save_done_o(sdn));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic give_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int k);
        if (k >= 60) begin
            failures++;
            give_verdict();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 60);
        rd = dato;
        cyc <= 1'b0;
        bound(n);
        @(posedge clk_i);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic ac(input logic f, input ces_pkg::ces_master_e m, input ces_pkg::ces_size_e s,
        input logic [31:0] a, input logic e);
        acc <= '{1'b1, f, m, s, a};
        @(posedge clk_i);
        acc.valid <= 1'b0;
        #1;
        chk(32'(abt), 32'(e));
        @(posedge clk_i);
    endtask
    task automatic irq_on(input ces_pkg::ces_src_e s, input logic [3:0] l, input logic [8:0] v);
        irq <= '{1'b1, s, l, v};
    endtask
    // Runs one entry and compares vector read, both pushes, handler and bank save
    task automatic ent(input logic [8:0] v, input logic [31:0] r, input logic [31:0] s, input logic b);
        logic sb;
        logic [31:0] va;
        sb = 1'b0;
        va = 32'h1000 + {21'h0, v, 2'b00};
        chk(32'(mrq), 32'h0);
        insn <= 1'b1;
        @(posedge clk_i);
        insn <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (iak === 1'b1) irq.req <= 1'b0;
            if (bsv === 1'b1) sb = 1'b1;
        end while (jmp !== 1'b1 && n < 60);
        bound(n);
        chk(p.addr_q[0], va);
        chk(p.addr_q[1], 32'h7FFC);
        chk(p.data_q[1], s);
        chk(p.addr_q[2], 32'h7FF8);
        chk(p.data_q[2], r);
        chk(jpc, 32'hA0000000 | va);
        chk(32'(sb), 32'(b));
        @(posedge clk_i);
    endtask
    initial begin
        rst_i = 1'b1;
        {cyc, we, insn, rb, adr, wdat} = '0;
        acc = '0;
        irq = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc(ces_pkg::ADR_STATUS, ces_pkg::STATUS_RST);
        rdc(ces_pkg::ADR_VBASE, 32'h0);
        rdc(ces_pkg::ADR_CTRL, 32'h0);
        rdc(8'h10, 32'h0);
        wb(1'b1, ces_pkg::ADR_VBASE, 32'h1000);
        wb(1'b1, ces_pkg::ADR_STATUS, 32'h50);
        $display("test reset and registers done");
        ac(1'b1, ces_pkg::MS_CPU, ces_pkg::SZ_WORD, 32'h1000, 1'b0);
        ac(1'b0, ces_pkg::MS_DMA, ces_pkg::SZ_LONG, 32'hFFFC0004, 1'b0);
        ac(1'b0, ces_pkg::MS_DTC, ces_pkg::SZ_BYTE, 32'hFFFC0003, 1'b0);
        ac(1'b0, ces_pkg::MS_CPU, ces_pkg::SZ_DLONG, 32'h2008, 1'b0);
        ac(1'b1, ces_pkg::MS_CPU, ces_pkg::SZ_WORD, 32'h1001, 1'b1);
        ac(1'b1, ces_pkg::MS_CPU, ces_pkg::SZ_WORD, 32'hF5FFFFFE, 1'b1);
        ac(1'b0, ces_pkg::MS_CPU, ces_pkg::SZ_DLONG, 32'h2004, 1'b1);
        wb(1'b1, ces_pkg::ADR_CTRL, 32'h1);
        ac(1'b0, ces_pkg::MS_CPU, ces_pkg::SZ_LONG, 32'h04000000, 1'b1);
        wb(1'b1, ces_pkg::ADR_CTRL, 32'h0);
        ent(ces_pkg::VEC_CPU_AE, 32'h3000, 32'h50, 1'b0);
        ac(1'b0, ces_pkg::MS_DMA, ces_pkg::SZ_WORD, 32'h2001, 1'b1);
        ac(1'b0, ces_pkg::MS_DTC, ces_pkg::SZ_LONG, 32'h2002, 1'b1);
        ent(ces_pkg::VEC_DMA_AE, 32'h3000, 32'h50, 1'b0);
        $display("test address errors done");
        irq_on(ces_pkg::IS_NORMAL, 4'h5, 9'h040);
        insn <= 1'b1;
        @(posedge clk_i);
        insn <= 1'b0;
        n = 0;
        repeat (20) begin
            @(posedge clk_i);
            n += int'(iak | mrq);
        end
        chk(n, 32'h0);
        irq.level <= 4'h6;
        ent(9'h040, 32'h3000, 32'h50, 1'b0);
        rdc(ces_pkg::ADR_STATUS, 32'h60);
        wb(1'b1, ces_pkg::ADR_CTRL, 32'h2);
        irq_on(ces_pkg::IS_NMI, 4'h0, 9'h00B);
        ent(9'h00B, 32'h3000, 32'h60, 1'b0);
        rdc(ces_pkg::ADR_STATUS, 32'hF0);
        wb(1'b1, ces_pkg::ADR_STATUS, 32'hE0);
        irq_on(ces_pkg::IS_BREAK, 4'h0, 9'h00C);
        ent(9'h00C, 32'h3000, 32'hE0, 1'b0);
        $display("test interrupts done");
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, ces_pkg::ADR_STATUS, 32'h0);
            irq_on(ces_pkg::IS_NORMAL, 4'h3, 9'h040);
            if (i == 15) wb(1'b1, ces_pkg::ADR_CTRL, 32'h6);
            if (i == 15) ent(ces_pkg::VEC_BANK_OVF, 32'h3000, 32'h0, 1'b0);
            else ent(9'h040, 32'h3000, 32'h0, 1'b1);
        end
        rdc(ces_pkg::ADR_STATUS, 32'h30);
        for (int i = 0; i < 16; i++) begin
            rb <= 1'b1;
            @(posedge clk_i);
            rb <= 1'b0;
            @(posedge clk_i);
            chk(32'(rok), 32'(i < 15));
        end
        ent(ces_pkg::VEC_BANK_UDF, 32'h2FFE, 32'h30, 1'b0);
        $display("test register banks done");
        give_verdict();
    end
endmodule
`default_nettype wire
